// >>> adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_OFF   = 8'h00;
  localparam logic [7:0] CONFIG_OFF    = 8'h04;
  localparam logic [7:0] TEMP_OFF      = 8'h08;
  localparam logic [7:0] PINSEL_LO_OFF = 8'h0C;
  localparam logic [7:0] PINSEL_HI_OFF = 8'h10;
  localparam logic [7:0] STATUS_OFF    = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CHAN_LSB   = 0;
  localparam int POWER_BIT  = 5;
  localparam int BUSY_BIT   = 6;
  localparam int START_BIT  = 7;
  localparam int DIV_LSB    = 0;
  localparam int REF_LSB    = 3;
  localparam int SRC_LSB    = 5;
  localparam int TEMP_SENSOR_ENABLE_BIT   = 0;
  localparam int ST_BUSY    = 0;
  localparam int ST_SAMPLE  = 1;
  localparam int ST_CONVERT = 2;
  localparam int ST_DIV_LSB = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] CHAN_RESET   = 4'h0;
  localparam logic [2:0] DIV_RESET    = 3'h0;
  localparam logic [1:0] REF_RESET    = 2'h0;
  localparam logic [2:0] SRC_RESET    = 3'h0;
  localparam logic [8:0] PINSEL_RESET = 9'h000;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_TEMP      = 3'h2;
  localparam logic [2:0] SRC_FORBIDDEN = 3'h7;
  localparam logic [1:0] REF_PIN       = 2'h0;
  localparam logic [1:0] REF_TEMP      = 2'h2;
  localparam int         PIN_COUNT     = 9;
  localparam int         RESERVED_CHAN = 4;
  localparam int         INT_SOURCES   = 5;

  // ----------------------------------------------------------------
  // Conversion timing in converter clocks
  // ----------------------------------------------------------------
  localparam logic [5:0] SAMPLE_CLKS      = 6'h04;
  localparam logic [5:0] TEMP_SAMPLE_CLKS = 6'h2E;
  localparam logic [5:0] CONVERT_CLKS     = 6'h0C;
  localparam logic [6:0] TOTAL_CLKS       = 7'h10;
  localparam logic [6:0] TEMP_TOTAL_CLKS  = 7'h3A;

  typedef enum logic [2:0] {
    IDLE    = 3'b001,
    SAMPLE  = 3'b010,
    CONVERT = 3'b100
  } conv_state_t;

endpackage : adc_ctrl_pkg

// >>> adc_clock_divider.sv
`timescale 1ns/100ps

module adc_clock_divider
  import adc_ctrl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       ce,
  input  wire logic       hold,
  input  wire logic [2:0] divide_select,
  output logic            conv_tick,
  output logic [2:0]      active_divide
);

  logic [6:0] free_count;
  logic [6:0] tick_mask;

  // ----------------------------------------------------------------
  // Free-running prescaler
  // ----------------------------------------------------------------
  // Counter runs on every enabled system clock
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      free_count <= 7'h00;
    else if (ce)
      free_count <= free_count + 7'h01;
  end

  // Divider code only follows software while the converter is idle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      active_divide <= DIV_RESET;
    else if (ce && !hold)
      active_divide <= divide_select;
  end

  // One tick every two-to-the-code enabled clocks
  always_comb
  begin
    tick_mask = 7'((8'h01 << active_divide) - 8'h01);
    conv_tick = ce && ((free_count & tick_mask) == tick_mask);
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  fast_tick_a : assert property (@(posedge clk) disable iff (!reset_n)
    ce && active_divide == 3'h0 |-> conv_tick)
    else $error("undivided setting missed a tick");

  half_tick_a : assert property (@(posedge clk) disable iff (!reset_n)
    (conv_tick && active_divide == 3'h1) ##1 (ce && active_divide == 3'h1) |-> !conv_tick)
    else $error("divide by two ticked twice in a row");

  divider_hold_a : assert property (@(posedge clk) disable iff (!reset_n)
    hold |=> $stable(active_divide))
    else $error("divider changed during a conversion");

endmodule : adc_clock_divider

// >>> adc_converter_control.sv
// Operation
// - Converter clock is system clock over two-to-code
// - Converter powered only while enable bit high
// - Reference codes 01 and 11 pick supply
// - Reference code 10 picks temperature sensor reference
// - Reference code 00 picks external reference pin
// - Analog pin role disables other pin functions
// - Pull-up disconnected on analog input pins
// - Analog role overrides port direction register
// - External source decodes channels 0-3 and 5-8
// - Channel codes 1100-1111 connect no pin
// - Source codes 001-101 pick internal nodes
// - Input source never takes code 111
// - Normal conversion: 4 sample, 12 convert clocks
// - Temperature conversion: 46 sample, 12 convert clocks
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps

module adc_converter_control
  import adc_ctrl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [8:0]  port_dir_output,
  input  wire logic [8:0]  pullup_request,
  output logic [8:0]       pin_output_enable,
  output logic [8:0]       pin_pullup_connect,
  output logic [8:0]       pin_digital_enable,
  output logic [8:0]       pin_analog_connect,
  output logic [8:0]       ext_channel_connect,
  output logic [4:0]       internal_source_connect,
  output logic             ref_from_supply,
  output logic             ref_from_temp_sensor,
  output logic             ref_from_pin,
  output logic             converter_power,
  output logic             temp_sensor_power,
  output logic             conv_tick,
  output logic             sample_phase,
  output logic             convert_phase,
  output logic             conversion_busy,
  output logic             conv_done
);

  import adc_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [3:0]  external_channel_select;
  logic        converter_power_enable;
  logic        start_bit;
  logic [2:0]  conv_clock_divide_select;
  logic [1:0]  reference_source_select;
  logic [2:0]  input_source_select;
  logic        temp_sensor_enable;
  logic [8:0]  pin_function_select_low;
  logic [8:0]  pin_function_select_high;
  logic [8:0]  analog_role;
  logic [2:0]  active_divide;
  logic        setup_seen;
  logic        bad_addr;
  logic        addr_hit;
  logic [31:0] read_value;
  logic        apb_write;
  logic        start_go;
  conv_state_t state;
  logic [5:0]  phase_count;
  logic [5:0]  sample_last;
  logic        temp_conversion;
  logic [6:0]  tick_hist;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Address decode against the map
  always_comb
  begin
    addr_hit = (paddr == CONTROL_OFF) || (paddr == CONFIG_OFF) || (paddr == TEMP_OFF)
            || (paddr == PINSEL_LO_OFF) || (paddr == PINSEL_HI_OFF) || (paddr == STATUS_OFF);
  end

  // Read mux, sampled into prdata during the setup cycle
  always_comb
  begin
    read_value = 32'h0000_0000;
    unique case (paddr)
      CONTROL_OFF:
      begin
        read_value[CHAN_LSB +: 4] = external_channel_select;
        read_value[POWER_BIT]     = converter_power_enable;
        read_value[BUSY_BIT]      = conversion_busy;
        read_value[START_BIT]     = start_bit;
      end
      CONFIG_OFF:
      begin
        read_value[DIV_LSB +: 3] = conv_clock_divide_select;
        read_value[REF_LSB +: 2] = reference_source_select;
        read_value[SRC_LSB +: 3] = input_source_select;
      end
      TEMP_OFF:      read_value[TEMP_SENSOR_ENABLE_BIT] = temp_sensor_enable;
      PINSEL_LO_OFF: read_value[8:0] = pin_function_select_low;
      PINSEL_HI_OFF: read_value[8:0] = pin_function_select_high;
      STATUS_OFF:
      begin
        read_value[ST_BUSY]          = conversion_busy;
        read_value[ST_SAMPLE]        = sample_phase;
        read_value[ST_CONVERT]       = convert_phase;
        read_value[ST_DIV_LSB +: 3]  = active_divide;
      end
      default:       read_value = 32'h0000_0000;
    endcase
  end

  // Setup cycle captures read data and the error answer
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      setup_seen <= 1'b0;
      prdata     <= 32'h0000_0000;
      bad_addr   <= 1'b0;
    end
    else if (ce)
    begin
      if (psel && !penable)
      begin
        setup_seen <= 1'b1;
        prdata     <= read_value;
        bad_addr   <= !addr_hit;
      end
      else if (pready)
        setup_seen <= 1'b0;
    end
  end

  // Zero-wait answer in the first access cycle while enabled
  assign pready    = psel && penable && setup_seen && ce;
  assign pslverr   = pready && bad_addr;
  assign apb_write = pready && pwrite && !bad_addr;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Control word: channel, power and start
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      external_channel_select <= CHAN_RESET;
      converter_power_enable  <= 1'b0;
      start_bit               <= 1'b0;
    end
    else if (ce && apb_write && paddr == CONTROL_OFF)
    begin
      external_channel_select <= pwdata[CHAN_LSB +: 4];
      converter_power_enable  <= pwdata[POWER_BIT];
      start_bit               <= pwdata[START_BIT];
    end
  end

  // Configuration word; forbidden source code leaves the field alone
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      conv_clock_divide_select <= DIV_RESET;
      reference_source_select  <= REF_RESET;
      input_source_select      <= SRC_RESET;
    end
    else if (ce && apb_write && paddr == CONFIG_OFF)
    begin
      conv_clock_divide_select <= pwdata[DIV_LSB +: 3];
      reference_source_select  <= pwdata[REF_LSB +: 2];
      if (pwdata[SRC_LSB +: 3] != SRC_FORBIDDEN)
        input_source_select <= pwdata[SRC_LSB +: 3];
    end
  end

  // Temperature sensor enable and pin function selects
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      temp_sensor_enable       <= 1'b0;
      pin_function_select_low  <= PINSEL_RESET;
      pin_function_select_high <= PINSEL_RESET;
    end
    else if (ce && apb_write)
    begin
      if (paddr == TEMP_OFF)
        temp_sensor_enable <= pwdata[TEMP_SENSOR_ENABLE_BIT];
      if (paddr == PINSEL_LO_OFF)
        pin_function_select_low <= pwdata[8:0];
      if (paddr == PINSEL_HI_OFF)
        pin_function_select_high <= pwdata[8:0];
    end
  end

  // ----------------------------------------------------------------
  // Converter clock
  // ----------------------------------------------------------------
  adc_clock_divider u_divider (
    .clk           (clk),
    .reset_n       (reset_n),
    .ce            (ce),
    .hold          (conversion_busy),
    .divide_select (conv_clock_divide_select),
    .conv_tick     (conv_tick),
    .active_divide (active_divide)
  );

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  // Start fires when the start bit is written back from one to zero
  assign start_go = apb_write && paddr == CONTROL_OFF && start_bit && !pwdata[START_BIT]
                 && converter_power_enable && pwdata[POWER_BIT] && state == IDLE;
  assign sample_last = temp_conversion ? TEMP_SAMPLE_CLKS - 6'h01 : SAMPLE_CLKS - 6'h01;

  // Sampling then conversion, counted in converter clocks
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state           <= IDLE;
      phase_count     <= 6'h00;
      temp_conversion <= 1'b0;
      conv_done       <= 1'b0;
    end
    else if (ce)
    begin
      conv_done <= 1'b0;
      if (!converter_power_enable)
      begin
        state       <= IDLE;
        phase_count <= 6'h00;
      end
      else
      begin
        unique case (state)
          IDLE:
          begin
            if (start_go)
            begin
              state           <= SAMPLE;
              phase_count     <= 6'h00;
              temp_conversion <= (input_source_select == SRC_TEMP);
            end
          end
          SAMPLE:
          begin
            if (conv_tick && phase_count == sample_last)
            begin
              state       <= CONVERT;
              phase_count <= 6'h00;
            end
            else if (conv_tick)
              phase_count <= phase_count + 6'h01;
          end
          CONVERT:
          begin
            if (conv_tick && phase_count == CONVERT_CLKS - 6'h01)
            begin
              state       <= IDLE;
              phase_count <= 6'h00;
              conv_done   <= 1'b1;
            end
            else if (conv_tick)
              phase_count <= phase_count + 6'h01;
          end
          default:
          begin
            state       <= IDLE;
            phase_count <= 6'h00;
          end
        endcase
      end
    end
  end

  assign sample_phase    = (state == SAMPLE);
  assign convert_phase   = (state == CONVERT);
  assign conversion_busy = (state != IDLE);

  // Converter clocks seen since the last start, read only by checks
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      tick_hist <= 7'h00;
    else if (ce && start_go)
      tick_hist <= 7'h00;
    else if (ce && conversion_busy && conv_tick)
      tick_hist <= tick_hist + 7'h01;
  end

  // ----------------------------------------------------------------
  // Analog routing
  // ----------------------------------------------------------------
  // Power and reference selection
  always_comb
  begin
    converter_power      = converter_power_enable;
    temp_sensor_power    = temp_sensor_enable;
    ref_from_supply      = reference_source_select[0];
    ref_from_temp_sensor = (reference_source_select == REF_TEMP);
    ref_from_pin         = (reference_source_select == REF_PIN);
  end

  // Internal node select; code n picks node n-1
  generate
    for (genvar s = 0; s < INT_SOURCES; s++)
    begin : g_source
      assign internal_source_connect[s] = (input_source_select == 3'(s + 1));
    end
  endgenerate

  // Per-pin channel decode and pin function override
  generate
    for (genvar p = 0; p < PIN_COUNT; p++)
    begin : g_pin
      assign ext_channel_connect[p] = (p != RESERVED_CHAN) && (external_channel_select == 4'(p));
      assign analog_role[p]         = pin_function_select_low[p] && pin_function_select_high[p];
      assign pin_analog_connect[p]  = analog_role[p];
      assign pin_digital_enable[p]  = !analog_role[p];
      assign pin_pullup_connect[p]  = pullup_request[p] && !analog_role[p];
      assign pin_output_enable[p]   = port_dir_output[p] && !analog_role[p];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence start_seq;
    ce && start_go;
  endsequence

  sequence sampling_seq;
    sample_phase && conversion_busy;
  endsequence

  property start_p;
    @(posedge clk) disable iff (!reset_n) start_seq |=> sampling_seq;
  endproperty

  conv_start_a : assert property (start_p)
    else $error("start did not enter sampling");

  power_off_a : assert property (@(posedge clk) disable iff (!reset_n)
    ce && !converter_power_enable |=> !conversion_busy)
    else $error("conversion survived power off");

  normal_length_a : assert property (@(posedge clk) disable iff (!reset_n)
    conv_done && !temp_conversion |-> tick_hist == TOTAL_CLKS)
    else $error("normal conversion length wrong");

  temp_length_a : assert property (@(posedge clk) disable iff (!reset_n)
    conv_done && temp_conversion |-> tick_hist == TEMP_TOTAL_CLKS)
    else $error("temperature conversion length wrong");

  source_legal_a : assert property (@(posedge clk) disable iff (!reset_n)
    input_source_select != SRC_FORBIDDEN)
    else $error("forbidden input source held");

  supply_ref_a : assert property (@(posedge clk) disable iff (!reset_n)
    reference_source_select[0] |-> ref_from_supply && !ref_from_pin && !ref_from_temp_sensor)
    else $error("supply reference not selected");

  temp_ref_a : assert property (@(posedge clk) disable iff (!reset_n)
    reference_source_select == REF_TEMP |-> ref_from_temp_sensor && !ref_from_supply)
    else $error("temperature reference not selected");

  pin_ref_a : assert property (@(posedge clk) disable iff (!reset_n)
    reference_source_select == REF_PIN |-> ref_from_pin && !ref_from_supply)
    else $error("pin reference not selected");

  no_pin_a : assert property (@(posedge clk) disable iff (!reset_n)
    external_channel_select[3:2] == 2'h3 |-> ext_channel_connect == 9'h000)
    else $error("parked channel still connects a pin");

  channel_map_a : assert property (@(posedge clk) disable iff (!reset_n)
    external_channel_select == 4'h5 |-> ext_channel_connect == 9'h020)
    else $error("channel five decoded wrongly");

  analog_pin_a : assert property (@(posedge clk) disable iff (!reset_n)
    ((pin_pullup_connect | pin_output_enable | pin_digital_enable) & analog_role) == 9'h000)
    else $error("analog pin kept a digital function");

  temp_source_a : assert property (@(posedge clk) disable iff (!reset_n)
    input_source_select == SRC_TEMP |-> internal_source_connect == 5'h02)
    else $error("temperature node not routed");

endmodule : adc_converter_control

// >>> adc_clock_reference_input_select_tb_top.sv
`timescale 1ns/100ps

module adc_clock_reference_input_select_tb_top;
  import adc_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk, reset_n, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [8:0]  port_dir_output, pullup_request, pin_output_enable, pin_pullup_connect;
  logic [8:0]  pin_digital_enable, pin_analog_connect, ext_channel_connect;
  logic [4:0]  internal_source_connect;
  logic        ref_from_supply, ref_from_temp_sensor, ref_from_pin, converter_power;
  logic        temp_sensor_power, conv_tick, sample_phase, convert_phase;
  logic        conversion_busy, conv_done;
  int          error_cnt, checks;

  adc_converter_control dut (
    .clk(clk), .reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_dir_output(port_dir_output), .pullup_request(pullup_request),
    .pin_output_enable(pin_output_enable), .pin_pullup_connect(pin_pullup_connect),
    .pin_digital_enable(pin_digital_enable), .pin_analog_connect(pin_analog_connect),
    .ext_channel_connect(ext_channel_connect), .internal_source_connect(internal_source_connect),
    .ref_from_supply(ref_from_supply), .ref_from_temp_sensor(ref_from_temp_sensor),
    .ref_from_pin(ref_from_pin), .converter_power(converter_power),
    .temp_sensor_power(temp_sensor_power), .conv_tick(conv_tick), .sample_phase(sample_phase),
    .convert_phase(convert_phase), .conversion_busy(conversion_busy), .conv_done(conv_done)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compare and count
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(negedge clk); // Let register writes settle before callers look
  endtask : apb

  task automatic report_and_stop;
    if (error_cnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reference decode for every code, temperature sensor power
  task automatic ref_scenario;
    logic [31:0] rd;
    logic        e;
    for (int r = 0; r < 4; r++)
    begin
      apb(1'b1, CONFIG_OFF, 32'(r << 3), rd, e);
      chk("ref_supply", ref_from_supply, r == 1 || r == 3);
      chk("ref_temp", ref_from_temp_sensor, r == 2);
      chk("ref_pin", ref_from_pin, r == 0);
    end
    apb(1'b1, TEMP_OFF, 32'h1, rd, e);
    chk("temp_power", temp_sensor_power, 1'b1);
  endtask : ref_scenario

  // Channel decode across all sixteen codes
  task automatic chan_scenario;
    logic [31:0] rd;
    logic        e;
    for (int c = 0; c < 16; c++)
    begin
      apb(1'b1, CONTROL_OFF, 32'(c), rd, e);
      chk("ext_channel", ext_channel_connect, (c <= 3 || (c >= 5 && c <= 8)) ? 32'(1 << c) : 32'h0);
    end
  endtask : chan_scenario

  // Internal source decode, forbidden code dropped
  task automatic src_scenario;
    logic [31:0] rd;
    logic        e;
    for (int s = 0; s < 7; s++)
    begin
      apb(1'b1, CONFIG_OFF, 32'(s << 5), rd, e);
      chk("int_source", internal_source_connect, (s >= 1 && s <= 5) ? 32'(1 << (s - 1)) : 32'h0);
    end
    apb(1'b1, CONFIG_OFF, 32'hE0, rd, e);
    apb(1'b0, CONFIG_OFF, 32'h0, rd, e);
    chk("src_readback", rd[7:5], 3'h6);
    chk("int_source_111", internal_source_connect, 5'h00);
  endtask : src_scenario

  // Analog role of pins against direction and pull-up requests
  task automatic pin_scenario;
    logic [31:0] rd;
    logic        e;
    @(posedge clk);
    port_dir_output <= 9'h1FF;
    pullup_request  <= 9'h1AA;
    apb(1'b1, PINSEL_LO_OFF, 32'h0F0, rd, e);
    apb(1'b1, PINSEL_HI_OFF, 32'h0CC, rd, e);
    chk("analog_connect", pin_analog_connect, 9'h0C0);
    chk("digital_enable", pin_digital_enable, 9'h13F);
    chk("pullup_connect", pin_pullup_connect, 9'h12A);
    chk("output_enable", pin_output_enable, 9'h13F);
  endtask : pin_scenario

  // Tick spacing for every divider code
  task automatic divider_scenario;
    logic [31:0] rd;
    logic        e;
    int          n;
    for (int d = 0; d < 8; d++)
    begin
      apb(1'b1, CONFIG_OFF, 32'(d), rd, e);
      apb(1'b0, STATUS_OFF, 32'h0, rd, e);
      chk("active_divide", rd[6:4], 32'(d));
      do @(posedge clk); while (conv_tick !== 1'b1);
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end while (conv_tick !== 1'b1);
      chk("tick_spacing", 32'(n), 32'(1 << d));
    end
  endtask : divider_scenario

  // Full conversion at divide by thirty-two, counting phase ticks
  task automatic convert_scenario(input logic [2:0] src, input int exp_sample);
    logic [31:0] rd;
    logic        e;
    int          ns, nc, n;
    apb(1'b1, CONFIG_OFF, {24'h0, src, 2'b01, 3'h5}, rd, e);
    apb(1'b1, CONTROL_OFF, 32'hAC, rd, e);
    apb(1'b1, CONTROL_OFF, 32'h2C, rd, e);
    ns = 0; nc = 0; n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (conv_tick === 1'b1 && sample_phase === 1'b1) ns++;
      if (conv_tick === 1'b1 && convert_phase === 1'b1) nc++;
    end while (conv_done !== 1'b1 && n < 4000);
    chk("done_seen", conv_done, 1'b1);
    chk("sample_ticks", 32'(ns), 32'(exp_sample));
    chk("convert_ticks", 32'(nc), 32'd12);
    chk("busy_at_done", conversion_busy, 1'b0);
  endtask : convert_scenario

  // Divider held while busy, power-off abort, start without power
  task automatic abort_scenario;
    logic [31:0] rd;
    logic        e;
    int          dones;
    apb(1'b1, CONFIG_OFF, 32'h1, rd, e);
    apb(1'b1, CONTROL_OFF, 32'hA0, rd, e);
    apb(1'b1, CONTROL_OFF, 32'h20, rd, e);
    apb(1'b1, CONFIG_OFF, 32'h3, rd, e);
    apb(1'b0, STATUS_OFF, 32'h0, rd, e);
    chk("busy_mid", rd[0], 1'b1);
    chk("held_divide", rd[6:4], 3'h1);
    @(posedge clk);
    ce <= 1'b0;
    repeat (40) @(posedge clk);
    chk("frozen_busy", conversion_busy, 1'b1);
    chk("frozen_tick", conv_tick, 1'b0);
    ce <= 1'b1;
    apb(1'b1, CONTROL_OFF, 32'h0, rd, e);
    chk("power_off", converter_power, 1'b0);
    dones = 0;
    repeat (80) @(posedge clk) if (conv_done === 1'b1) dones++;
    chk("abort_done", 32'(dones), 32'h0);
    chk("abort_busy", conversion_busy, 1'b0);
    apb(1'b0, STATUS_OFF, 32'h0, rd, e);
    chk("new_divide", rd[6:4], 3'h3);
    apb(1'b1, CONTROL_OFF, 32'h80, rd, e);
    apb(1'b1, CONTROL_OFF, 32'h00, rd, e);
    @(posedge clk);
    chk("no_power_start", conversion_busy, 1'b0);
  endtask : abort_scenario

  // ----------------------------------------------------------------
  // Clock, reset and sequence
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #20 clk = ~clk;

  initial
  begin
    logic [31:0] rd;
    logic        e;
    reset_n = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; port_dir_output = 9'h000; pullup_request = 9'h000;
    error_cnt = 0; checks = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    chk("reset_ref_pin", ref_from_pin, 1'b1);
    chk("reset_channel", ext_channel_connect, 9'h001);
    apb(1'b0, CONFIG_OFF, 32'h0, rd, e);
    chk("reset_config", rd, 32'h0);
    apb(1'b0, 8'h3C, 32'h0, rd, e);
    chk("unmapped_err", e, 1'b1);
    ref_scenario();
    chan_scenario();
    src_scenario();
    pin_scenario();
    divider_scenario();
    convert_scenario(3'h0, 4);
    convert_scenario(SRC_TEMP, 46);
    abort_scenario();
    report_and_stop();
  end

  // Watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end

endmodule : adc_clock_reference_input_select_tb_top
